// [cca_top.sv]
`timescale 1ns/1ps
`include "cca_consts.svh"
module cca_top (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire cca_pkg::cca_addr_t reg_addr,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire cca_pkg::cca_word_t reg_wdata,
    output cca_pkg::cca_word_t reg_rdata,
    input wire conv_done,
    input wire avg_enable,
    input wire cca_pkg::cca_word_t sense_sample,
    input wire cca_pkg::cca_word_t sense_avg,
    input wire cca_pkg::cca_word_t bus_voltage,
    input wire cca_pkg::cca_word_t power_value,
    output logic alert_o,
    output logic alert_oe
);
    import cca_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    cca_state_t state_r, state_nxt;
    cca_word_t sense_op_r;
    cca_word_t bus_op_r;
    cca_word_t power_op_r;
    cca_word_t current_r, current_nxt;
    cca_word_t cal_r;
    cca_word_t limit_r;
    logic [5:0] enables_r;
    logic alert_output_polarity_r;
    logic ale_r;
    logic limit_function_flag_r, limit_function_flag_nxt;
    logic conversion_done_flag_r, conversion_done_flag_nxt;
    logic arithmetic_overflow_flag_r, arithmetic_overflow_flag_nxt;
    cca_word_t rdata_r, rdata_nxt;

    ////////////////////////////////////////////////////////////////////
    // register decode
    wire hit_cal = reg_addr == `CCA_ADDR_CAL;
    wire hit_mask = reg_addr == `CCA_ADDR_MASK;
    wire hit_limit = reg_addr == `CCA_ADDR_LIMIT;
    wire hit_cur = reg_addr == `CCA_ADDR_CURRENT;
    wire wr_cal = reg_wr_en && hit_cal;
    wire wr_mask = reg_wr_en && hit_mask;
    wire wr_limit = reg_wr_en && hit_limit;
    wire rd_mask = reg_rd_en && hit_mask;

    // mask word as software sees it; flags are read-only and unused bits read zero
    wire cca_word_t mask_word;
    assign mask_word[`CCA_SENSE_OVER_BIT:`CCA_CONV_ALERT_BIT] = enables_r;
    assign mask_word[9:5] = 5'h00;
    assign mask_word[`CCA_LIMIT_FLAG_BIT] = limit_function_flag_r;
    assign mask_word[`CCA_CONV_FLAG_BIT] = conversion_done_flag_r;
    assign mask_word[`CCA_OVERFLOW_BIT] = arithmetic_overflow_flag_r;
    assign mask_word[`CCA_POLARITY_BIT] = alert_output_polarity_r;
    assign mask_word[`CCA_ALE_BIT] = ale_r;

    ////////////////////////////////////////////////////////////////////
    // operand pick and multiply
    // averaged value replaces the raw sample whenever averaging runs
    wire cca_word_t sense_pick = avg_enable ? sense_avg : sense_sample;
    // bit 15 of calibration is held at zero so it always scales as positive
    wire signed [16:0] cal_s = {2'b00, cal_r[14:0]};
    wire signed [32:0] product = $signed({sense_op_r[15], sense_op_r}) * cal_s;
    wire signed [32:0] scaled = product >>> `CCA_CUR_SHIFT;
    // result fits when bits 32..15 all match the sign
    wire fits = (scaled[32:15] == {18{1'b0}}) || (scaled[32:15] == {18{1'b1}});
    wire neg = scaled[32];
    // two's complement keeps bit 15 as the polarity and 14:0 as value;
    // overflow saturates rather than wrapping so the sign stays honest
    wire cca_word_t cur_calc = fits ? scaled[15:0] : (neg ? `CCA_NEG_SAT : `CCA_POS_SAT);

    ////////////////////////////////////////////////////////////////////
    // limit comparisons, all against the alert limit register
    wire [4:0] cmp_hit;
    cca_limit_cmp #(.IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_sense_over (
        .value(sense_op_r),
        .limit(limit_r),
        .hit(cmp_hit[4])
    );
    cca_limit_cmp #(.IS_SIGNED(1'b1), .IS_OVER(1'b0)) u_sense_under (
        .value(sense_op_r),
        .limit(limit_r),
        .hit(cmp_hit[3])
    );
    cca_limit_cmp #(.IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_bus_over (
        .value(bus_op_r),
        .limit(limit_r),
        .hit(cmp_hit[2])
    );
    cca_limit_cmp #(.IS_SIGNED(1'b0), .IS_OVER(1'b0)) u_bus_under (
        .value(bus_op_r),
        .limit(limit_r),
        .hit(cmp_hit[1])
    );
    cca_limit_cmp #(.IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_power_over (
        .value(power_op_r),
        .limit(limit_r),
        .hit(cmp_hit[0])
    );

    // enables_r[5:1] map to bits 15..11; only the highest set one counts
    wire [4:0] lim_en = enables_r[5:1];
    // conversion ready alert sits outside the limit priority chain
    wire conversion_done_alert_enable = enables_r[0];
    wire fault = lim_en[4] ? cmp_hit[4] :
                 lim_en[3] ? cmp_hit[3] :
                 lim_en[2] ? cmp_hit[2] :
                 lim_en[1] ? cmp_hit[1] :
                 lim_en[0] ? cmp_hit[0] : 1'b0;
    // one view of each sequence step so every register uses the same decode
    wire capturing = (state_r == CCA_IDLE) && conv_done;
    wire calculating = state_r == CCA_CALC;
    wire finishing = state_r == CCA_FINISH;

    ////////////////////////////////////////////////////////////////////
    // sequence: capture, multiply, publish; a new conv_done while busy is dropped
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CCA_IDLE: begin
                if (conv_done) begin
                    state_nxt = CCA_CALC;
                end
            end
            CCA_CALC: state_nxt = CCA_FINISH;
            CCA_FINISH: state_nxt = CCA_IDLE;
            default: state_nxt = CCA_IDLE;
        endcase
    end

    // current result only moves once the product is final, so a read never sees half a result
    assign current_nxt = calculating ? cur_calc : current_r;
    // overflow describes the latest conversion only; an older overflow does not linger
    assign arithmetic_overflow_flag_nxt = calculating ? !fits : arithmetic_overflow_flag_r;

    // latched: set wins over read clear, so a fault landing with the read is not lost
    wire flag_latched_nxt = (finishing && fault) || (limit_function_flag_r && !rd_mask);
    // transparent: follows each conversion; a read leaves it alone
    wire flag_follow_nxt = finishing ? fault : limit_function_flag_r;
    assign limit_function_flag_nxt = ale_r ? flag_latched_nxt : flag_follow_nxt;
    // ready flag cleared by a mask read unless a result lands the same cycle
    assign conversion_done_flag_nxt = finishing || (conversion_done_flag_r && !rd_mask);

    ////////////////////////////////////////////////////////////////////
    // read mux, registered; unmapped offsets read zero
    assign rdata_nxt = !reg_rd_en ? rdata_r :
                       hit_cur ? current_r :
                       hit_cal ? cal_r :
                       hit_mask ? mask_word :
                       hit_limit ? limit_r : `CCA_RST_WORD;

    ////////////////////////////////////////////////////////////////////
    // sequencing and result registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= CCA_IDLE;
            current_r <= `CCA_RST_WORD;
            arithmetic_overflow_flag_r <= 1'b0;
            limit_function_flag_r <= 1'b0;
            conversion_done_flag_r <= 1'b0;
            rdata_r <= `CCA_RST_WORD;
        end else if (clk_en) begin
            state_r <= state_nxt;
            current_r <= current_nxt;
            arithmetic_overflow_flag_r <= arithmetic_overflow_flag_nxt;
            limit_function_flag_r <= limit_function_flag_nxt;
            conversion_done_flag_r <= conversion_done_flag_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // operands captured on conv_done so comparison and product agree
    // a conv_done while busy is ignored, so operands never change mid-calculation
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sense_op_r <= `CCA_RST_WORD;
            bus_op_r <= `CCA_RST_WORD;
            power_op_r <= `CCA_RST_WORD;
        end else if (clk_en && capturing) begin
            sense_op_r <= sense_pick;
            bus_op_r <= bus_voltage;
            power_op_r <= power_value;
        end
    end

    // software-written registers
    // write strobes are ignored while clk_en is low, like every other state change
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cal_r <= `CCA_RST_WORD;
            limit_r <= `CCA_RST_WORD;
            enables_r <= 6'h00;
            alert_output_polarity_r <= 1'b0;
            ale_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_cal) begin
                cal_r <= reg_wdata & `CCA_CAL_WR_BITS;
            end
            if (wr_limit) begin
                limit_r <= reg_wdata;
            end
            if (wr_mask) begin
                enables_r <= reg_wdata[`CCA_SENSE_OVER_BIT:`CCA_CONV_ALERT_BIT];
                alert_output_polarity_r <= reg_wdata[`CCA_POLARITY_BIT];
                ale_r <= reg_wdata[`CCA_ALE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // open-drain alert: pin only ever pulled low, enable decides
    // only one limit function drives the flag, but conversion ready may alert alongside it
    wire limit_alert = limit_function_flag_r;
    wire ready_alert = conversion_done_alert_enable && conversion_done_flag_r;
    wire alert_active = limit_alert || ready_alert;
    // active-low pulls while alerting; active-high pulls while idle
    assign alert_oe = alert_active ^ alert_output_polarity_r;
    assign alert_o = 1'b0;
    assign reg_rdata = rdata_r;
endmodule : cca_top

// [cca_consts.svh]
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// register offsets
`define CCA_ADDR_CURRENT 8'h04
`define CCA_ADDR_CAL 8'h05
`define CCA_ADDR_MASK 8'h06
`define CCA_ADDR_LIMIT 8'h07

////////////////////////////////////////////////////////////////////////
// reset values
`define CCA_RST_WORD 16'h0000

////////////////////////////////////////////////////////////////////////
// alert select control field positions
`define CCA_SENSE_OVER_BIT 15
`define CCA_SENSE_UNDER_BIT 14
`define CCA_BUS_OVER_BIT 13
`define CCA_BUS_UNDER_BIT 12
`define CCA_POWER_OVER_BIT 11
`define CCA_CONV_ALERT_BIT 10
`define CCA_LIMIT_FLAG_BIT 4
`define CCA_CONV_FLAG_BIT 3
`define CCA_OVERFLOW_BIT 2
`define CCA_POLARITY_BIT 1
`define CCA_ALE_BIT 0
// bits software may write: 15..10 and 1..0
`define CCA_MASK_WR_BITS 16'hfc03
// calibration carries bits 14..0 only
`define CCA_CAL_WR_BITS 16'h7fff

////////////////////////////////////////////////////////////////////////
// product scaling: right shift applied to sense times calibration
`define CCA_CUR_SHIFT 11
`define CCA_POS_SAT 16'h7fff
`define CCA_NEG_SAT 16'h8000

`endif

// [cca_pkg.sv]
package cca_pkg;
    typedef logic [15:0] cca_word_t;
    typedef logic [7:0] cca_addr_t;
    // state encoding for one conversion result: IDLE 00, CALC 01, FINISH 11
    typedef enum logic [1:0] {
        CCA_IDLE = 2'b00,
        CCA_CALC = 2'b01,
        CCA_FINISH = 2'b11
    } cca_state_t;
endpackage : cca_pkg

// [cca_limit_cmp.sv]
`timescale 1ns/1ps
module cca_limit_cmp #(
    parameter bit IS_SIGNED = 1'b0,
    parameter bit IS_OVER = 1'b1
) (
    input wire cca_pkg::cca_word_t value,
    input wire cca_pkg::cca_word_t limit,
    output logic hit
);
    import cca_pkg::*;
    wire gt_s = $signed(value) > $signed(limit);
    wire lt_s = $signed(value) < $signed(limit);
    wire gt_u = value > limit;
    wire lt_u = value < limit;
    wire gt = IS_SIGNED ? gt_s : gt_u;
    wire lt = IS_SIGNED ? lt_s : lt_u;
    // one comparison per instance, direction fixed at build time
    assign hit = IS_OVER ? gt : lt;
endmodule : cca_limit_cmp

// [cca_top_chk.sv]
`timescale 1ns/1ps
module cca_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire cca_pkg::cca_addr_t reg_addr,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire cca_pkg::cca_word_t reg_wdata,
    input wire cca_pkg::cca_word_t reg_rdata,
    input wire conv_done,
    input wire alert_o,
    input wire alert_oe
);
    import cca_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // quiet: no conv_done or write this cycle; once a conversion in flight has finished, only a read may move the flags
    wire quiet = clk_en && !conv_done && !reg_wr_en;
    wire rd6 = clk_en && reg_rd_en && reg_addr == 8'h06;
    wire latch_seen = reg_rdata[0];
    ////////////////////////////////////////////////////////////////
    // write, one idle cycle, then read of the same place
    sequence s_wr_rd(a);
        clk_en && reg_wr_en && reg_addr == a ##1 clk_en && !reg_wr_en ##1 quiet && reg_rd_en && reg_addr == a;
    endsequence
    sequence s_two_rd;
        quiet [*3] ##1 quiet && rd6 ##1 quiet ##1 quiet && rd6;
    endsequence
    AST_CAL_WR: assert property (s_wr_rd(8'h05) |=> reg_rdata == ($past(reg_wdata, 3) & 16'h7fff))
        else $error("cal readback");
    AST_MASK_WR: assert property (s_wr_rd(8'h06) |=> reg_rdata[15:10] == $past(reg_wdata[15:10], 3))
        else $error("mask readback");
    AST_CAL_TOP: assert property (clk_en && reg_rd_en && reg_addr == 8'h05 |=> !reg_rdata[15])
        else $error("cal bit 15 set");
    AST_RSVD: assert property (rd6 |=> reg_rdata[9:5] == 5'h00)
        else $error("mask reserved bits");
    AST_HOLD: assert property (!(clk_en && reg_rd_en) |=> $stable(reg_rdata))
        else $error("rdata moved");
    AST_CAUSE: assert property ($changed(alert_oe) |-> $past(reg_wr_en) || $past(reg_rd_en) || $past(conv_done, 3))
        else $error("alert moved alone");
    AST_PIN: assert property (alert_o == 1'b0)
        else $error("alert pin driven high");
    AST_RD_CLR: assert property (s_two_rd |=> !reg_rdata[3] && (!$past(latch_seen, 2) || !reg_rdata[4]))
        else $error("flag not cleared");
endmodule : cca_chk
bind cca_top cca_chk i_chk (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
    .conv_done, .alert_o, .alert_oe);

// [cca_host.sv]
`timescale 1ns/1ps
module cca_host (
    input wire sys_clk,
    output cca_pkg::cca_addr_t reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output cca_pkg::cca_word_t reg_wdata,
    input wire cca_pkg::cca_word_t reg_rdata
);
    import cca_pkg::*;
    // idle bus from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 16'h0000;
    end
    // lines flip on release so a stale value never passes for a fresh one
    task automatic wr(input cca_addr_t a, input cca_word_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // read data is registered, so it is taken just after the edge ending the strobe
    task automatic rd(input cca_addr_t a, output cca_word_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd
endmodule : cca_host

// [tb_current_calc_alert_select.sv]
`timescale 1ns/1ps
module tb_current_calc_alert_select;
    import cca_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic conv_done = 1'b0;
    logic avg_enable = 1'b0;
    cca_word_t sense_sample = 16'h0000;
    cca_word_t sense_avg = 16'h0000;
    cca_word_t bus_voltage = 16'h0000;
    cca_word_t power_value = 16'h0000;
    cca_addr_t reg_addr;
    logic reg_wr_en;
    logic reg_rd_en;
    cca_word_t reg_wdata;
    cca_word_t reg_rdata;
    logic alert_o;
    logic alert_oe;
    int error_cnt = 0;
    int samples_checked = 0;
    cca_top i_dut (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata, .conv_done,
        .avg_enable, .sense_sample, .sense_avg, .bus_voltage, .power_value, .alert_o, .alert_oe);
    cca_host i_host (.sys_clk, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata);
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input cca_word_t g, e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input cca_addr_t a, input cca_word_t m, e);
        cca_word_t v;
        i_host.rd(a, v);
        chk($sformatf("reg %h", a), v & m, e);
    endtask : rdc
    task automatic oe(input logic e);
        #1 chk("alert_oe", {15'h0, alert_oe}, {15'h0, e});
        // pull-up model: a released pin floats high, a driven pin shows alert_o
        chk("alert pin", {15'h0, alert_oe ? alert_o : 1'b1}, {15'h0, !e});
    endtask : oe
    // conv_done is one cycle; flags settle two edges after capture
    task automatic conv(input cca_word_t s, a, b);
        @(posedge sys_clk);
        sense_sample <= s;
        sense_avg <= a;
        bus_voltage <= b;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : conv
    task automatic cur(input cca_word_t c, s, a, e, input logic ae);
        i_host.wr(8'h05, c);
        avg_enable <= ae;
        conv(s, a, 16'h0000);
        rdc(8'h04, 16'hffff, e);
    endtask : cur
    task automatic t_regs;
        for (int a = 4; a < 8; a++) begin
            rdc(cca_addr_t'(a), 16'hffff, 16'h0000);
        end
        i_host.wr(8'h05, 16'hffff);
        rdc(8'h05, 16'hffff, 16'h7fff);
        i_host.wr(8'h06, 16'hffff);
        rdc(8'h06, 16'hffff, 16'hfc03);
        oe(1'b1);
        i_host.wr(8'h06, 16'h0000);
        oe(1'b0);
        i_host.wr(8'h04, 16'h1234);
        i_host.wr(8'h08, 16'h0001);
        rdc(8'h04, 16'hffff, 16'h0000);
        @(posedge sys_clk) clk_en <= 1'b0;
        i_host.wr(8'h05, 16'h0555);
        clk_en <= 1'b1;
        rdc(8'h05, 16'hffff, 16'h7fff);
        $display("register test done");
    endtask : t_regs
    task automatic t_current;
        cur(16'h0800, 16'h8300, 16'h0000, 16'h8300, 1'b0);
        cur(16'h0800, 16'h7000, 16'h0100, 16'h0100, 1'b1);
        cur(16'h1000, 16'h0123, 16'h0000, 16'h0246, 1'b0);
        cur(16'h1000, 16'h7000, 16'h0000, 16'h7fff, 1'b0);
        rdc(8'h06, 16'h0004, 16'h0004);
        $display("current test done");
    endtask : t_current
    task automatic t_alert;
        cca_word_t am [9] = '{16'h8000, 16'h8000, 16'h4000, 16'h2000, 16'hc000, 16'hc000,
            16'h1000, 16'h3000, 16'h0800};
        cca_word_t sv [9] = '{16'h0200, 16'h0080, 16'h0080, 16'h0000, 16'h0080, 16'h0200,
            16'h0200, 16'h0000, 16'h0000};
        logic ex [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        i_host.wr(8'h07, 16'h0100);
        for (int i = 0; i < 9; i++) begin
            i_host.wr(8'h06, am[i]);
            power_value <= {am[i] == 16'h0800, 15'h0000};
            conv(sv[i], 16'h0000, {6'h00, am[i] == 16'h2000, 9'h000});
            oe(ex[i]);
        end
        i_host.wr(8'h06, 16'h0002);
        oe(1'b0);
        conv(16'h0000, 16'h0000, 16'h0000);
        oe(1'b1);
        i_host.wr(8'h06, 16'h8001);
        conv(16'h0200, 16'h0000, 16'h0000);
        conv(16'h0000, 16'h0000, 16'h0000);
        oe(1'b1);
        rdc(8'h06, 16'h0019, 16'h0019);
        oe(1'b0);
        rdc(8'h06, 16'h0018, 16'h0000);
        i_host.wr(8'h06, 16'h8000);
        conv(16'h0200, 16'h0000, 16'h0000);
        conv(16'h0000, 16'h0000, 16'h0000);
        oe(1'b0);
        rdc(8'h06, 16'h0010, 16'h0000);
        i_host.wr(8'h06, 16'h0400);
        oe(1'b0);
        conv(16'h0000, 16'h0000, 16'h0000);
        oe(1'b1);
        rdc(8'h06, 16'h0418, 16'h0408);
        oe(1'b0);
        $display("alert test done");
    endtask : t_alert
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_current();
        t_alert();
        summarize();
    end
    // hang guard: a run this long counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
endmodule : tb_current_calc_alert_select
